//--- verilog/rgb_insert_pkg.sv
// package: constants, register map and carrier types for the rgb insertion port control
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package rgb_insert_pkg;

  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;
  localparam int PORT_W  = 7;
  localparam int LEVEL_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_KEY_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MONITOR   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_HC_CTRL   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PORT_OUT  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_PORT_DIR  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_PORT_PIN  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PIN_MUX   = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_EXT_BRT_A = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_EXT_CON_A = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_EXT_BRT_B = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_EXT_CON_B = 4'hA;

  // key control bit positions
  localparam int KC_POL   = 0;
  localparam int KC_PREF  = 1;
  localparam int KC_FOH_A = 2;
  localparam int KC_FOH_B = 3;
  localparam int KC_FOL_A = 4;
  localparam int KC_FOL_B = 5;
  localparam int KC_MON_B = 6;
  // half contrast control: force, polarity, reduction code
  localparam int HC_FORCE = 0;
  localparam int HC_POL   = 1;
  localparam int HC_RED_L = 2;
  localparam int HC_RED_W = 2;
  // pin mux bits
  localparam int MX_HC    = 0;
  localparam int MX_FSY   = 1;
  localparam int MX_COLOR = 2;
  // monitor status bits
  localparam int MON_STATIC  = 0;
  localparam int MON_DYNAMIC = 1;

  localparam logic [DATA_W-1:0] RST_KEY_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_HC_CTRL  = 8'h00;
  localparam logic [PORT_W-1:0] RST_PORT_DIR = 7'h00;
  localparam logic [DATA_W-1:0] RST_PIN_MUX  = 8'h04;
  localparam logic [LEVEL_W-1:0] RST_BRT     = 8'h00;
  localparam logic [LEVEL_W-1:0] RST_CON     = 8'h80;
  localparam logic [DATA_W-1:0] UNMAPPED     = 8'h00;

  // reduction in quarters of full scale: 25, 50, 75, 75 percent
  localparam logic [1:0] GAIN_75 = 2'h3;
  localparam logic [1:0] GAIN_25 = 2'h1;

  typedef enum logic [1:0] {SRC_VIDEO, SRC_EXT_A, SRC_EXT_B} source_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] bright;
    logic [LEVEL_W-1:0] contrast;
  } ext_level_t;

  typedef struct packed {
    source_t            source;
    logic               ext_priority;
    logic               clamp_a;
    logic               clamp_b;
    logic               half_contrast;
    logic [1:0]         video_gain_q;
    ext_level_t         level_a;
    ext_level_t         level_b;
  } insert_ctl_t;

endpackage

//--- verilog/rgb_insert_ctrl.sv
// rgb insertion source selection, blank monitor, half contrast and port expander
`timescale 1ns/10ps
module rgb_insert_ctrl
  import rgb_insert_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic              mclk_in,
  input  wire logic              srst_in,
  input  wire reg_req_t          req_in,
  output logic [DATA_W-1:0]      rdata_out,
  input  wire logic              blank_key_in_a,
  input  wire logic              blank_key_in_b,
  input  wire logic              clamp_pulse_in,
  input  wire logic              front_sync_in,
  input  wire logic [PORT_W-1:0] port_pin_in,
  output logic [PORT_W-1:0]      port_pin_out,
  output logic [PORT_W-1:0]      port_pin_oe_out,
  output logic [4:0]             color_bus_out,
  output insert_ctl_t            ctl_out
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_STAGES-1:0]        sync_a;
    logic [SYNC_STAGES-1:0]        sync_b;
    logic [SYNC_STAGES-1:0]        sync_hc;
    logic [PORT_W*SYNC_STAGES-1:0] sync_pin;
    logic               key_a;
    logic               key_b;
    logic               hc_key;
    logic [PORT_W-1:0]  pin_now;
    logic               mon_prev;
    logic               mon_dyn;
    logic [DATA_W-1:0]  key_ctrl;
    logic [DATA_W-1:0]  hc_ctrl;
    logic [PORT_W-1:0]  port_out;
    logic [PORT_W-1:0]  port_dir;
    logic [DATA_W-1:0]  pin_mux;
    ext_level_t         lev_a;
    ext_level_t         lev_b;
    logic [DATA_W-1:0]  rdata;
    insert_ctl_t        ctl;
  } state_t;

  state_t st;
  state_t next_st;

  // --------------------------------------------------------------------------
  // source decode, used by selection logic
  // --------------------------------------------------------------------------
  function automatic source_t pick_source(input logic a, input logic b,
                                          input logic pol, input logic pref);
    logic [1:0] k;
    k = {a, b};
    if (!pol) begin
      unique case (k)
        2'h0: pick_source = SRC_VIDEO;
        2'h1: pick_source = SRC_EXT_B;
        2'h2: pick_source = SRC_EXT_A;
        default: pick_source = pref ? SRC_EXT_B : SRC_EXT_A;
      endcase
    end else begin
      unique case (k)
        2'h0: pick_source = pref ? SRC_EXT_B : SRC_EXT_A;
        2'h1: pick_source = SRC_EXT_A;
        2'h2: pick_source = SRC_EXT_B;
        default: pick_source = SRC_VIDEO;
      endcase
    end
  endfunction

  // accept a change only when the second and third stages agree
  function automatic logic settle(input logic [SYNC_STAGES-1:0] s, input logic held);
    settle = (s[SYNC_STAGES-2] == s[SYNC_STAGES-1]) ? s[SYNC_STAGES-1] : held;
  endfunction

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic eff_a;
    logic eff_b;
    logic mon;
    logic hc_on;
    logic [1:0] red;
    logic [PORT_W-1:0] pin_rd;
    eff_a   = 1'b0;
    eff_b   = 1'b0;
    mon     = 1'b0;
    hc_on   = 1'b0;
    red     = 2'h0;
    pin_rd  = '0;
    next_st = st;

    // pin synchronisers
    next_st.sync_a  = {st.sync_a[SYNC_STAGES-2:0], blank_key_in_a};
    next_st.sync_b  = {st.sync_b[SYNC_STAGES-2:0], blank_key_in_b};
    next_st.sync_hc = {st.sync_hc[SYNC_STAGES-2:0], port_pin_in[0]};
    next_st.key_a   = settle(st.sync_a, st.key_a);
    next_st.key_b   = settle(st.sync_b, st.key_b);
    next_st.hc_key  = settle(st.sync_hc, st.hc_key);
    for (int i = 0; i < PORT_W; i++) begin
      next_st.sync_pin[i*SYNC_STAGES +: SYNC_STAGES] =
        {st.sync_pin[i*SYNC_STAGES +: SYNC_STAGES-1], port_pin_in[i]};
      next_st.pin_now[i] = settle(st.sync_pin[i*SYNC_STAGES +: SYNC_STAGES], st.pin_now[i]);
    end

    // blank monitor
    mon = st.key_ctrl[KC_MON_B] ? st.key_b : st.key_a;
    next_st.mon_prev = mon;

    // forces override the settled key levels
    eff_a = (st.key_a | st.key_ctrl[KC_FOH_A]) & ~st.key_ctrl[KC_FOL_A];
    eff_b = (st.key_b | st.key_ctrl[KC_FOH_B]) & ~st.key_ctrl[KC_FOL_B];
    next_st.ctl.source = pick_source(eff_a, eff_b, st.key_ctrl[KC_POL],
                                     st.key_ctrl[KC_PREF]);
    // external source is offered on the priority path as a bus source
    next_st.ctl.ext_priority = (next_st.ctl.source != SRC_VIDEO);
    next_st.ctl.clamp_a = clamp_pulse_in;
    next_st.ctl.clamp_b = clamp_pulse_in;
    next_st.ctl.level_a = st.lev_a;
    next_st.ctl.level_b = st.lev_b;

    // half contrast: only applied while video is the chosen source
    hc_on = st.hc_ctrl[HC_FORCE] |
            (st.pin_mux[MX_HC] & (st.hc_key ^ st.hc_ctrl[HC_POL]));
    next_st.ctl.half_contrast = hc_on & (next_st.ctl.source == SRC_VIDEO);
    red = st.hc_ctrl[HC_RED_L +: HC_RED_W];
    // reduction code 0..2 gives 25/50/75 percent, 3 clips to 75
    next_st.ctl.video_gain_q = (red == 2'h3) ? GAIN_25 : GAIN_75 - red;

    // port pin readback: settled pins, with pin 0 read as zero while it is the half contrast input
    pin_rd = st.pin_now;
    if (st.pin_mux[MX_HC]) begin
      pin_rd[0] = 1'b0;
    end

    next_st.rdata = UNMAPPED;
    if (req_in.rd) begin
      unique case (req_in.addr)
        ADDR_KEY_CTRL:  next_st.rdata = st.key_ctrl;
        ADDR_MONITOR: begin
          next_st.rdata[MON_STATIC]  = mon;
          next_st.rdata[MON_DYNAMIC] = st.mon_dyn;
        end
        ADDR_HC_CTRL:   next_st.rdata = st.hc_ctrl;
        ADDR_PORT_OUT:  next_st.rdata = {1'b0, st.port_out};
        ADDR_PORT_DIR:  next_st.rdata = {1'b0, st.port_dir};
        ADDR_PORT_PIN:  next_st.rdata = {1'b0, pin_rd};
        ADDR_PIN_MUX:   next_st.rdata = st.pin_mux;
        ADDR_EXT_BRT_A: next_st.rdata = st.lev_a.bright;
        ADDR_EXT_CON_A: next_st.rdata = st.lev_a.contrast;
        ADDR_EXT_BRT_B: next_st.rdata = st.lev_b.bright;
        ADDR_EXT_CON_B: next_st.rdata = st.lev_b.contrast;
        default:        next_st.rdata = UNMAPPED;
      endcase
    end

    // reading the monitor clears the dynamic flag; a new edge wins
    if (req_in.rd && req_in.addr == ADDR_MONITOR) begin
      next_st.mon_dyn = 1'b0;
    end
    if (st.mon_prev && !mon) begin
      next_st.mon_dyn = 1'b1;
    end

    if (req_in.wr) begin
      unique case (req_in.addr)
        ADDR_KEY_CTRL:  next_st.key_ctrl = req_in.wdata;
        ADDR_HC_CTRL:   next_st.hc_ctrl = req_in.wdata;
        ADDR_PORT_OUT: begin
          next_st.port_out[PORT_W-1:1] = req_in.wdata[PORT_W-1:1];
          if (!st.pin_mux[MX_HC]) begin
            next_st.port_out[0] = req_in.wdata[0];
          end
        end
        ADDR_PORT_DIR:  next_st.port_dir = req_in.wdata[PORT_W-1:0];
        ADDR_PIN_MUX:   next_st.pin_mux = req_in.wdata;
        ADDR_EXT_BRT_A: next_st.lev_a.bright = req_in.wdata;
        ADDR_EXT_CON_A: next_st.lev_a.contrast = req_in.wdata;
        ADDR_EXT_BRT_B: next_st.lev_b.bright = req_in.wdata;
        ADDR_EXT_CON_B: next_st.lev_b.contrast = req_in.wdata;
        default: ;
      endcase
    end

    if (srst_in) begin
      next_st          = '0;
      next_st.key_ctrl = RST_KEY_CTRL;
      next_st.hc_ctrl  = RST_HC_CTRL;
      next_st.port_dir = RST_PORT_DIR;
      next_st.pin_mux  = RST_PIN_MUX;
      next_st.lev_a    = '{bright: RST_BRT, contrast: RST_CON};
      next_st.lev_b    = '{bright: RST_BRT, contrast: RST_CON};
      next_st.ctl.level_a = '{bright: RST_BRT, contrast: RST_CON};
      next_st.ctl.level_b = '{bright: RST_BRT, contrast: RST_CON};
      next_st.ctl.video_gain_q = GAIN_75;
    end
  end

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  // --------------------------------------------------------------------------
  // pin drive
  // --------------------------------------------------------------------------
  always_comb begin
    port_pin_out    = st.port_out;
    port_pin_oe_out = st.port_dir;
    if (st.pin_mux[MX_HC]) begin
      port_pin_oe_out[0] = 1'b0;
    end
    if (st.pin_mux[MX_FSY]) begin
      port_pin_out[1]    = front_sync_in;
      port_pin_oe_out[1] = 1'b1;
    end
    if (st.pin_mux[MX_COLOR]) begin
      port_pin_oe_out[PORT_W-1:2] = '0;
    end
  end

  // colour bus taps the settled pins while it owns them
  assign color_bus_out = st.pin_mux[MX_COLOR] ? st.pin_now[PORT_W-1:2] : 5'h00;
  assign rdata_out     = st.rdata;
  assign ctl_out       = st.ctl;

endmodule

//--- test/rgb_insert_ctrl_chk.sv
// concurrent checks on the ports of the rgb insertion port control
`timescale 1ns/10ps
module rgb_insert_ctrl_chk
  import rgb_insert_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic              mclk_in,
  input wire logic              srst_in,
  input wire reg_req_t          req_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic              blank_key_in_a,
  input wire logic              blank_key_in_b,
  input wire logic              clamp_pulse_in,
  input wire logic              front_sync_in,
  input wire logic [PORT_W-1:0] port_pin_in,
  input wire logic [PORT_W-1:0] port_pin_out,
  input wire logic [PORT_W-1:0] port_pin_oe_out,
  input wire logic [4:0]        color_bus_out,
  input wire insert_ctl_t       ctl_out
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  chk_rdata_idle: assert property (!req_in.rd |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_read: assert property (req_in.rd && req_in.addr > ADDR_EXT_CON_B
    |=> rdata_out == UNMAPPED) else $error("unmapped read not zero");
  chk_monitor_pad: assert property (req_in.rd && req_in.addr == ADDR_MONITOR
    |=> rdata_out[7:2] == 6'h00) else $error("monitor status wider than two bits");
  chk_clamp_follow: assert property (clamp_pulse_in
    |=> ctl_out.clamp_a && ctl_out.clamp_b) else $error("clamp pulse not passed on");
  chk_hc_external: assert property (ctl_out.source != SRC_VIDEO
    |-> !ctl_out.half_contrast) else $error("half contrast on external source");
  chk_gain_range: assert property (ctl_out.video_gain_q != 2'h0)
    else $error("video gain outside 25 to 75 percent");
  chk_source_legal: assert property (ctl_out.source inside {SRC_VIDEO, SRC_EXT_A, SRC_EXT_B})
    else $error("illegal source code");
  chk_colour_oe: assert property (color_bus_out != 5'h00
    |-> port_pin_oe_out[6:2] == 5'h00) else $error("colour pins driven while owned");
  // sync chain is 3 deep plus the settled key stage and one output stage, so 6 quiet cycles must settle it
  chk_key_settle: assert property (($stable(blank_key_in_a) && $stable(blank_key_in_b)
    && !req_in.wr) [*6] |=> $stable(ctl_out.source)) else $error("source moved on quiet keys");

  cover property (ctl_out.source == SRC_EXT_B);
  cover property (ctl_out.half_contrast);
  cover property (req_in.rd && req_in.addr == ADDR_MONITOR ##1 rdata_out[MON_DYNAMIC]);
endmodule

//--- test/ext_rgb_source.sv
// model of the external rgb sources feeding the blank keys and the port pins
`timescale 1ns/10ps
module ext_rgb_source
  import rgb_insert_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              pol_in,
  input  wire logic              act_a_in,
  input  wire logic              act_b_in,
  input  wire logic [PORT_W-1:0] pin_lvl_in,
  input  wire logic [PORT_W-1:0] pin_drv_in,
  input  wire logic [PORT_W-1:0] pin_oe_in,
  output logic                   key_a_out = 1'b0,
  output logic                   key_b_out = 1'b0,
  output logic [PORT_W-1:0]      pin_out
);
  // ----------------------------------------------------------------------
  // keys and pins
  // ----------------------------------------------------------------------
  // keys move only on a clock edge, standing in for flyback-aligned sources
  always @(posedge mclk_in) begin
    key_a_out <= act_a_in ^ pol_in;
    key_b_out <= act_b_in ^ pol_in;
  end
  // a pin the design drives shows the design's level, otherwise the source's
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pin_out[i] = (pin_oe_in[i] === 1'b1) ? pin_drv_in[i] : pin_lvl_in[i];
    end
  end
endmodule

//--- test/test_rgb_insert_ctrl.sv
// self-checking testbench for the rgb insertion port control
`timescale 1ns/10ps
module test_rgb_insert_ctrl;
  import rgb_insert_pkg::*;
  logic              mclk_in = 1'b0;
  logic              srst_in = 1'b1;
  reg_req_t          req_in = '0;
  logic              clamp_pulse_in = 1'b0;
  logic              front_sync_in = 1'b0;
  logic              act_a = 1'b0;
  logic              act_b = 1'b0;
  logic              pol = 1'b0;
  logic [PORT_W-1:0] pin_lvl = 7'h00;
  logic              blank_key_in_a;
  logic              blank_key_in_b;
  logic [PORT_W-1:0] port_pin_in;
  logic [PORT_W-1:0] port_pin_out;
  logic [PORT_W-1:0] port_pin_oe_out;
  logic [DATA_W-1:0] rdata_out;
  logic [4:0]        color_bus_out;
  insert_ctl_t       ctl_out;
  int                n_errors = 0;
  int                n_compared = 0;
  int                cycles = 0;
  logic [3:0]        ra [9] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF};
  logic [7:0]        rv [9] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};

  always #12.5 mclk_in = ~mclk_in;

  rgb_insert_ctrl #(.SYNC_STAGES(3)) u_dut (.mclk_in, .srst_in, .req_in, .rdata_out,
    .blank_key_in_a, .blank_key_in_b, .clamp_pulse_in, .front_sync_in, .port_pin_in,
    .port_pin_out, .port_pin_oe_out, .color_bus_out, .ctl_out);
  ext_rgb_source u_src (.mclk_in, .pol_in(pol), .act_a_in(act_a), .act_b_in(act_b),
    .pin_lvl_in(pin_lvl), .pin_drv_in(port_pin_out), .pin_oe_in(port_pin_oe_out),
    .key_a_out(blank_key_in_a), .key_b_out(blank_key_in_b), .pin_out(port_pin_in));

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req_in.rd <= 1'b0;
    #1 check({8'h00, rdata_out}, {8'h00, exp}, what);
  endtask
  // waits out the source register, the sync chain and the output stage
  task automatic drive(input logic a, input logic b, input logic p, input logic [6:0] pins);
    @(posedge mclk_in);
    act_a <= a;
    act_b <= b;
    pol <= p;
    pin_lvl <= pins;
    repeat (8) @(posedge mclk_in);
    #1;
  endtask
  function automatic source_t exp_src(input logic a, input logic b, input logic p,
                                      input logic f);
    if (a == b) return (a == p) ? SRC_VIDEO : (f ? SRC_EXT_B : SRC_EXT_A);
    return (a ^ p) ? SRC_EXT_A : SRC_EXT_B;
  endfunction
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("ERROR at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1 check(port_pin_oe_out, 7'h00, "oe after reset");
    foreach (ra[i]) rd(ra[i], rv[i], "reset value");
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_KEY_CTRL, {6'h00, i[3], i[2]});
      drive(i[0] ^ i[2], i[1] ^ i[2], i[2], 7'h00);
      check(ctl_out.source, exp_src(i[0], i[1], i[2], i[3]), "source");
      check(ctl_out.ext_priority, exp_src(i[0], i[1], i[2], i[3]) != SRC_VIDEO, "prio");
    end
    wr(ADDR_KEY_CTRL, 8'h04);
    drive(0, 0, 0, 7'h00);
    check(ctl_out.source, SRC_EXT_A, "force high a");
    wr(ADDR_KEY_CTRL, 8'h3C);
    drive(0, 0, 0, 7'h00);
    check(ctl_out.source, SRC_VIDEO, "force low beats high");
    $display("test source table done");
    wr(ADDR_KEY_CTRL, 8'h00);
    drive(1, 1, 0, 7'h00);
    rd(ADDR_MONITOR, 8'h03, "monitor a high");
    drive(0, 1, 0, 7'h00);
    rd(ADDR_MONITOR, 8'h02, "monitor a fell");
    rd(ADDR_MONITOR, 8'h00, "monitor cleared");
    wr(ADDR_KEY_CTRL, 8'h40);
    rd(ADDR_MONITOR, 8'h01, "monitor b high");
    drive(0, 0, 0, 7'h00);
    rd(ADDR_MONITOR, 8'h02, "monitor b fell");
    $display("test blank monitor done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_HC_CTRL, {4'h0, c[1:0], 2'b01});
      drive(0, 0, 0, 7'h00);
      check(ctl_out.half_contrast, 1'b1, "forced half contrast");
      check(ctl_out.video_gain_q, (c == 0) ? 2'h3 : (c == 1) ? 2'h2 : 2'h1, "gain");
    end
    drive(1, 0, 0, 7'h00);
    check(ctl_out.half_contrast, 1'b0, "external full contrast");
    wr(ADDR_HC_CTRL, 8'h00);
    wr(ADDR_PIN_MUX, 8'h05);
    wr(ADDR_PORT_DIR, 8'h01);
    wr(ADDR_PORT_OUT, 8'h01);
    drive(0, 0, 0, 7'h01);
    check(ctl_out.half_contrast, 1'b1, "half contrast pin");
    check(port_pin_oe_out[0], 1'b0, "pin 0 port disabled");
    wr(ADDR_HC_CTRL, 8'h02);
    drive(0, 0, 0, 7'h01);
    check(ctl_out.half_contrast, 1'b0, "half contrast inverted");
    wr(ADDR_PIN_MUX, 8'h04);
    wr(ADDR_HC_CTRL, 8'h00);
    drive(0, 0, 0, 7'h00);
    check(port_pin_out[0], 1'b0, "pin 0 write ignored");
    $display("test half contrast done");
    wr(ADDR_PIN_MUX, 8'h00);
    wr(ADDR_PORT_DIR, 8'h7F);
    wr(ADDR_PORT_OUT, 8'h55);
    drive(0, 0, 0, 7'h00);
    check(port_pin_out, 7'h55, "port out");
    check(port_pin_oe_out, 7'h7F, "port dir");
    rd(ADDR_PORT_OUT, 8'h55, "port out back");
    wr(ADDR_PORT_DIR, 8'h00);
    drive(0, 0, 0, 7'h2A);
    rd(ADDR_PORT_PIN, 8'h2A, "pin read");
    wr(ADDR_PIN_MUX, 8'h02);
    wr(ADDR_PORT_DIR, 8'h02);
    front_sync_in <= 1'b1;
    drive(0, 0, 0, 7'h00);
    check(port_pin_out[1], 1'b1, "front sync pin");
    wr(ADDR_PIN_MUX, 8'h04);
    drive(0, 0, 0, 7'h7C);
    check(color_bus_out, 5'h1F, "colour bus");
    rd(ADDR_PIN_MUX, 8'h04, "mux back");
    $display("test port expander done");
    wr(ADDR_EXT_BRT_A, 8'h12);
    wr(ADDR_EXT_CON_A, 8'h34);
    wr(ADDR_EXT_BRT_B, 8'h56);
    wr(ADDR_EXT_CON_B, 8'h78);
    @(posedge mclk_in);
    clamp_pulse_in <= 1'b1;
    @(posedge mclk_in);
    clamp_pulse_in <= 1'b0;
    #1 check({ctl_out.clamp_a, ctl_out.clamp_b}, 2'b11, "clamp");
    check(ctl_out.level_a, 16'h1234, "level a");
    check(ctl_out.level_b, 16'h5678, "level b");
    rd(ADDR_EXT_CON_B, 8'h78, "level back");
    wr(4'hF, 8'hFF);
    rd(4'hF, UNMAPPED, "unmapped");
    $display("test levels and clamp done");
    wrap_up();
  end
endmodule

bind rgb_insert_ctrl rgb_insert_ctrl_chk #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.mclk_in, .srst_in,
  .req_in, .rdata_out, .blank_key_in_a, .blank_key_in_b, .clamp_pulse_in, .front_sync_in,
  .port_pin_in, .port_pin_out, .port_pin_oe_out, .color_bus_out, .ctl_out);
